// *** hdl/sleep_timer_defs.vh ***
// Behaviour
// - 31-bit counter, one step per tick, restarts at 1 on wake
// - Resolution code picks 16-bit counter slice
// - Tick from crystal or RC divide-by-750
// - Wake events only in power modes 1-2
// - Wake event returns chip to active mode
// - Interval is mantissa times 2^(5*res) ticks
// - Mantissa resets to 0x87 and 0x6B
// - Low count byte rate follows resolution
// - RC calibrates with fast crystal in active/mode 1, else holds
// - Wake sets pending flag, masked CPU flag
// - Mask bit 4, pending bit 0, reset zero
// - Interrupt request when CPU flag and enable
// - Port interrupts blocked when mode not 00
// - DMA trigger pulse on every wake event
// - Low count byte read-only, slice bits 7:0
`ifndef SLEEP_TIMER_DEFS_VH
`define SLEEP_TIMER_DEFS_VH
`define ADDR_IRQ_CTRL 8'hA1
`define ADDR_CTRL 8'hA2
`define ADDR_MANT_LOW 8'hA3
`define ADDR_MANT_HIGH 8'hA4
`define ADDR_COUNT_LOW 8'hA5
`define ADDR_COUNT_HIGH 8'hA6
`define ADDR_CPU_IRQ 8'hA7
`define ADDR_POWER 8'hA8
`define BIT_EVENT_MASK 4
`define BIT_EVENT_FLAG 0
`define BIT_COUNT_RESET 2
`define BIT_CPU_FLAG 0
`define BIT_CPU_ENABLE 1
`define BIT_CAL_DONE 2
`define RESET_MANT_HIGH 8'h87
`define RESET_MANT_LOW 8'h6B
`define RESET_COUNT_VALUE 31'h00000004
`define RC_DIVIDE 750
`endif

// *** hdl/sleep_wakeup_timer.v ***
// Design decisions made here: the strobed register port and the register addresses.
`include "sleep_timer_defs.vh"
module sleep_wakeup_timer (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Register port
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata,
    // Slow clock sources
    input wire crystal_32k,
    input wire use_crystal,
    input wire hs_xosc_running,
    // Sleep mode field, 00 is active
    input wire [1:0] sleep_mode,
    // Events
    output wire sleep_irq_request,
    output reg sleep_dma_trigger,
    output reg wake_to_active,
    output wire port_irq_block
);
    reg rst_s1;
    reg rst_n;
    reg [30:0] count;
    reg [15:0] wake_interval_mantissa;
    reg [1:0] resolution;
    reg reset_pending;
    reg wake_event_irq_enable;
    reg wake_event_pending;
    reg sleep_irq_cpu_flag;
    reg sleep_irq_cpu_enable;
    reg [1:0] power_control_reg;
    wire tick;
    wire cal_valid;
    wire [15:0] slice;
    wire low_power;
    wire wake;

    function [15:0] pick_slice;
        input [30:0] c;
        input [1:0] r;
        begin
            case (r)
                2'h0: pick_slice = c[15:0];
                2'h1: pick_slice = c[20:5];
                2'h2: pick_slice = c[25:10];
                default: pick_slice = c[30:15];
            endcase
        end
    endfunction

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // Calibration runs only while the fast crystal runs in active or mode 1.
    slow_tick_gen #(.RC_DIV(`RC_DIVIDE)) u_tick (
        .clk(clk),
        .rst_n(rst_n),
        .use_crystal(use_crystal),
        .crystal_in(crystal_32k),
        .cal_enable(hs_xosc_running && (sleep_mode <= 2'h1)),
        .tick(tick),
        .cal_valid(cal_valid)
    );

    assign slice = pick_slice(count, resolution);
    assign low_power = (sleep_mode != 2'h0) && (sleep_mode != 2'h3);
    // The slice compare on a tick yields a period of mantissa << 5*res ticks.
    assign wake = tick && low_power && (slice == wake_interval_mantissa);
    assign port_irq_block = (sleep_mode != 2'h0);
    assign sleep_irq_request = sleep_irq_cpu_flag && sleep_irq_cpu_enable;

    // Counter reset is applied on the next tick, so it settles within two ticks.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 31'h00000000;
            reset_pending <= 1'b0;
        end else begin
            if (wr && addr == `ADDR_CTRL && wdata[`BIT_COUNT_RESET])
                reset_pending <= 1'b1;
            else if (tick)
                reset_pending <= 1'b0;
            if (tick) begin
                if (reset_pending)
                    count <= `RESET_COUNT_VALUE;
                else if (wake)
                    // Restarting at one counts the wake tick itself, so the period is exact.
                    count <= 31'h00000001;
                else
                    count <= count + 31'h00000001;
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_interval_mantissa <= {`RESET_MANT_HIGH, `RESET_MANT_LOW};
            resolution <= 2'h0;
            wake_event_irq_enable <= 1'b0;
            wake_event_pending <= 1'b0;
            sleep_irq_cpu_flag <= 1'b0;
            sleep_irq_cpu_enable <= 1'b0;
            power_control_reg <= 2'h0;
            sleep_dma_trigger <= 1'b0;
            wake_to_active <= 1'b0;
        end else begin
            sleep_dma_trigger <= wake;
            wake_to_active <= wake;
            if (wr) begin
                case (addr)
                    `ADDR_MANT_HIGH: wake_interval_mantissa[15:8] <= wdata;
                    `ADDR_MANT_LOW: wake_interval_mantissa[7:0] <= wdata;
                    `ADDR_CTRL: resolution <= wdata[1:0];
                    `ADDR_IRQ_CTRL: begin
                        wake_event_irq_enable <= wdata[`BIT_EVENT_MASK];
                        if (!wdata[`BIT_EVENT_FLAG])
                            wake_event_pending <= 1'b0;
                    end
                    `ADDR_CPU_IRQ: begin
                        sleep_irq_cpu_enable <= wdata[`BIT_CPU_ENABLE];
                        if (!wdata[`BIT_CPU_FLAG])
                            sleep_irq_cpu_flag <= 1'b0;
                    end
                    `ADDR_POWER: power_control_reg <= wdata[1:0];
                    default: ;
                endcase
            end
            // Set wins over a same-cycle software clear.
            if (wake) begin
                wake_event_pending <= 1'b1;
                if (wake_event_irq_enable)
                    sleep_irq_cpu_flag <= 1'b1;
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (rd) begin
            case (addr)
                `ADDR_COUNT_LOW: rdata <= slice[7:0];
                `ADDR_COUNT_HIGH: rdata <= slice[15:8];
                `ADDR_MANT_HIGH: rdata <= wake_interval_mantissa[15:8];
                `ADDR_MANT_LOW: rdata <= wake_interval_mantissa[7:0];
                `ADDR_CTRL: rdata <= {6'h00, resolution};
                `ADDR_IRQ_CTRL: rdata <= {3'h0, wake_event_irq_enable, 3'h0, wake_event_pending};
                `ADDR_CPU_IRQ: rdata <= {5'h00, cal_valid, sleep_irq_cpu_enable,
                                         sleep_irq_cpu_flag};
                `ADDR_POWER: rdata <= {6'h00, power_control_reg};
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule

// *** hdl/slow_tick_gen.v ***
`include "sleep_timer_defs.vh"
module slow_tick_gen #(
    parameter RC_DIV = `RC_DIVIDE
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Source selection
    input wire use_crystal,
    input wire crystal_in,
    input wire cal_enable,
    // Tick and calibration state
    output reg tick,
    output reg cal_valid
);
    reg crystal_prev;
    reg [9:0] rc_count;
    reg [9:0] rc_limit;
    localparam integer RC_LAST = RC_DIV - 1;

    // The RC divider restarts from zero and counts up to its held limit; calibration refreshes the limit.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crystal_prev <= 1'b0;
            rc_count <= 10'h000;
            // Start from the nominal divide so an uncalibrated RC never ticks every clock.
            rc_limit <= RC_LAST[9:0];
            cal_valid <= 1'b0;
            tick <= 1'b0;
        end else begin
            crystal_prev <= crystal_in;
            if (cal_enable) begin
                rc_limit <= RC_LAST[9:0];
                cal_valid <= 1'b1;
            end
            if (use_crystal) begin
                tick <= crystal_in & ~crystal_prev;
                rc_count <= 10'h000;
            end else if (rc_count >= rc_limit) begin
                tick <= 1'b1;
                rc_count <= 10'h000;
            end else begin
                tick <= 1'b0;
                rc_count <= rc_count + 10'h001;
            end
        end
    end
endmodule

// *** verification/sleep_wakeup_timer_props.sv ***
module sleep_wakeup_timer_props (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Register port
    input wire wr,
    input wire rd,
    input wire [7:0] rdata,
    // Mode and events
    input wire [1:0] sleep_mode,
    input wire sleep_irq_request,
    input wire sleep_dma_trigger,
    input wire wake_to_active,
    input wire port_irq_block
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    property p_block; port_irq_block == (sleep_mode != 2'h0); endproperty
    a_block: assert property (p_block) else $error("port block wrong");
    property p_pair; sleep_dma_trigger |-> wake_to_active; endproperty
    a_pair: assert property (p_pair) else $error("dma without wake");
    property p_dma; sleep_dma_trigger |=> !sleep_dma_trigger; endproperty
    a_dma: assert property (p_dma) else $error("dma pulse too long");
    property p_wake; wake_to_active |=> !wake_to_active; endproperty
    a_wake: assert property (p_wake) else $error("wake pulse too long");
    property p_mode; wake_to_active |-> $past(sleep_mode) inside {2'h1, 2'h2}; endproperty
    a_mode: assert property (p_mode) else $error("wake in wrong mode");
    property p_rd; rdata != 8'h00 |-> $past(rd); endproperty
    a_rd: assert property (p_rd) else $error("read data without read");
    property p_rise; $rose(sleep_irq_request) && !$past(wr) |-> ##[0:1] sleep_dma_trigger; endproperty
    a_rise: assert property (p_rise) else $error("request without wake");
    property p_fall; $fell(sleep_irq_request) |-> $past(wr); endproperty
    a_fall: assert property (p_fall) else $error("request dropped alone");
endmodule

bind sleep_wakeup_timer sleep_wakeup_timer_props chk (.clk(clk), .rst_b(rst_b), .wr(wr),
    .rd(rd), .rdata(rdata), .sleep_mode(sleep_mode), .sleep_irq_request(sleep_irq_request),
    .sleep_dma_trigger(sleep_dma_trigger), .wake_to_active(wake_to_active),
    .port_irq_block(port_irq_block));

// *** verification/sleep_wakeup_timer_test.sv ***
`include "sleep_timer_defs.vh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end
module sleep_wakeup_timer_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_b = 0, wr = 0, rd = 0, rd_q = 0, crystal_32k = 0;
    logic use_crystal = 1, hs_xosc_running = 0;
    logic [7:0] addr = 0, wdata = 0, rdata, exp_val;
    logic [15:0] mant;
    logic [1:0] sleep_mode = 0;
    logic sleep_irq_request, sleep_dma_trigger, wake_to_active, port_irq_block;
    logic [7:0] q[$];
    int failures = 0, n_tests = 0, ticks = 0, last = 0, wakes = 0;
    sleep_wakeup_timer uut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .crystal_32k(crystal_32k), .use_crystal(use_crystal),
        .hs_xosc_running(hs_xosc_running), .sleep_mode(sleep_mode),
        .sleep_irq_request(sleep_irq_request),
        .sleep_dma_trigger(sleep_dma_trigger), .wake_to_active(wake_to_active),
        .port_irq_block(port_irq_block));
    initial forever #5 clk = ~clk;
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    // The crystal is held steady for several clocks so each level is seen once.
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            crystal_32k <= 1'b1;
            ticks++;
            repeat (4) @(posedge clk);
            crystal_32k <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge clk) begin
        if (rd_q) begin
            exp_val = q.pop_front();
            `CHK(rdata, exp_val)
        end
        rd_q <= rd;
        if (sleep_dma_trigger) begin
            `CHK(wake_to_active, 1'b1)
            if (wakes > 0) `CHK(ticks - last, int'(mant))
            last = ticks;
            wakes++;
        end
    end
    initial begin
        void'($urandom(32'hE30F));
        mant = 16'h0190 + 16'($urandom % 4);
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        rreg(`ADDR_MANT_HIGH, 8'h87);
        rreg(`ADDR_MANT_LOW, 8'h6B);
        rreg(`ADDR_IRQ_CTRL, 8'h00);
        rreg(`ADDR_CPU_IRQ, 8'h00);
        hs_xosc_running <= 1'b1;
        rreg(`ADDR_CPU_IRQ, 8'h04);
        wreg(`ADDR_COUNT_LOW, 8'hFF);
        rreg(`ADDR_COUNT_LOW, 8'h00);
        rreg(8'h00, 8'h00);
        wreg(`ADDR_CTRL, 8'h04);
        tick(1);
        rreg(`ADDR_COUNT_LOW, 8'h04);
        tick(1);
        rreg(`ADDR_COUNT_LOW, 8'h05);
        wreg(`ADDR_CTRL, 8'h01);
        rreg(`ADDR_CTRL, 8'h01);
        tick(3);
        rreg(`ADDR_COUNT_LOW, 8'h00);
        wreg(`ADDR_CTRL, 8'h04);
        tick(2);
        wreg(`ADDR_MANT_HIGH, mant[15:8]);
        wreg(`ADDR_MANT_LOW, mant[7:0]);
        wreg(`ADDR_IRQ_CTRL, 8'h10);
        wreg(`ADDR_CPU_IRQ, 8'h02);
        // The count runs past the mantissa here, so a wake would be possible in mode 1 or 2.
        sleep_mode <= 2'h3;
        tick(mant + 8);
        `CHK(wakes, 0)
        `CHK(port_irq_block, 1'b1)
        wreg(`ADDR_CTRL, 8'h04);
        tick(2);
        sleep_mode <= 2'h2;
        tick(3 * mant);
        `CHK(wakes, 3)
        `CHK(sleep_irq_request, 1'b1)
        sleep_mode <= 2'h0;
        rreg(`ADDR_IRQ_CTRL, 8'h11);
        `CHK(port_irq_block, 1'b0)
        wreg(`ADDR_IRQ_CTRL, 8'h00);
        wreg(`ADDR_CPU_IRQ, 8'h02);
        rreg(`ADDR_IRQ_CTRL, 8'h00);
        `CHK(sleep_irq_request, 1'b0)
        sleep_mode <= 2'h1;
        tick(mant + 1);
        sleep_mode <= 2'h0;
        rreg(`ADDR_IRQ_CTRL, 8'h01);
        `CHK(sleep_irq_request, 1'b0)
        // RC source: first tick 751 clocks after the switch applies the reset, then one per 750.
        wreg(`ADDR_CTRL, 8'h04);
        use_crystal <= 1'b0;
        repeat (1200) @(posedge clk);
        rreg(`ADDR_COUNT_LOW, 8'h04);
        repeat (750) @(posedge clk);
        rreg(`ADDR_COUNT_LOW, 8'h05);
        rreg(`ADDR_COUNT_HIGH, 8'h00);
        print_verdict();
    end
endmodule
